// ===== verilog/dac_vol_consts.svh
// Offsets, field positions, reset values and timing counts of the playback control block
`ifndef DAC_VOL_CONSTS_SVH
`define DAC_VOL_CONSTS_SVH

// Register offsets on the control port
`define VOL_LEFT_OFS    8'h41
`define VOL_RIGHT_OFS   8'h42
`define HSET_OFS        8'h43
`define DRC1_OFS        8'h44

// Reset values
`define VOL_RST         8'h00
`define HSET_RST        8'h00
`define DRC1_RST        8'h0f
`define THR_RST_DB      5'h0c
`define HYST_RST_DB     2'h3

// Field positions
`define HSET_EN_BIT     7
`define DRC_LEFT_BIT    6
`define DRC_RIGHT_BIT   5

// Volume code limits in half-decibel steps
`define VOL_MAX         8'h30
`define VOL_MIN         8'h81
`define VOL_RSVD        8'h80

// Debounce timing from the 1 MHz reference tick
`define REF_HZ          1000000
`define MS_PER_SEC      1000
`define TICKS_PER_MS    (`REF_HZ / `MS_PER_SEC)
`define DBN_SAMPLES     4'h8
`define HS_MAX_IVAL_MS  7'h40

`endif

// ===== verilog/dac_vol_pkg.sv
// Types shared by the playback volume, headset and compressor control block
package dac_vol_pkg;

    // One stereo sample pair, index 0 is left
    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } stereo_s;

    // State of one debounce filter
    typedef struct packed {
        logic [1:0] cand;   // Value being qualified
        logic [1:0] stat;   // Accepted value
        logic [3:0] hits;   // Equal samples seen in a row
        logic [6:0] age;    // Milliseconds since last sample
    } dbn_s;

    // Whole state of the block
    typedef struct packed {
        logic [1:0][7:0]  vol;      // Programmed gain codes
        logic [1:0][7:0]  cur;      // Soft-stepped gain codes
        logic             half;     // Alternate-sample phase
        logic             hs_en;    // Detection enable
        logic [2:0]       hs_deb;   // Insertion debounce select
        logic [1:0]       btn_deb;  // Button debounce select
        logic [7:0]       drc;      // Compressor control byte
        logic [9:0]       us;       // Reference ticks in this millisecond
        logic             ms_p;     // Millisecond pulse
        dbn_s             hs;       // Insertion filter
        dbn_s             btn;      // Button filter
        logic [1:0][15:0] out;      // Scaled samples
        logic             out_vld;  // Scaled samples valid
        logic [1:0]       drc_en;   // Compressor enables to the stage
        logic [4:0]       thr_db;   // Threshold magnitude in dB
        logic [1:0]       hyst_db;  // Hysteresis in dB
        logic [7:0]       rdata;    // Read data
        logic             rvalid;   // Read data valid
    } regs_s;

endpackage

// ===== verilog/dac_volume_headset_drc_regs.sv
// Digital gain, headset detection and compressor control registers of the playback path
`timescale 1ns/1ns

module dac_volume_headset_drc_regs
    import dac_vol_pkg::*;
(
    input  wire logic        mclk_i,           // System clock
    input  wire logic        rst_i,            // Synchronous reset
    input  wire logic        reg_wr_i,         // Register write strobe
    input  wire logic        reg_rd_i,         // Register read strobe
    input  wire logic [7:0]  reg_addr_i,       // Register offset
    input  wire logic [7:0]  reg_wdata_i,      // Write data
    output logic      [7:0]  reg_rdata_o,      // Read data
    output logic             reg_rvalid_o,     // Read data valid
    input  wire logic [1:0]  step_mode_i,      // Soft-step rate select
    input  wire logic        tick_1mhz_i,      // Reference tick
    input  wire logic [1:0]  headset_sense_i,  // Raw insertion state
    input  wire logic        button_i,         // Raw button state
    input  wire logic        sample_valid_i,   // Routed sample strobe
    input  wire stereo_s     sample_i,         // Routed samples
    output logic             sample_valid_o,   // Scaled sample strobe
    output stereo_s          sample_o,         // Scaled samples
    output logic [1:0]       headset_status_o, // Debounced insertion state
    output logic             button_o,         // Debounced button state
    output logic [1:0]       drc_en_o,         // Compressor enables, bit 0 left
    output logic [4:0]       drc_thr_db_o,     // Threshold magnitude in dB
    output logic [1:0]       drc_hyst_db_o     // Hysteresis in dB
);

`include "dac_vol_consts.svh"

    regs_s q;    // Registered state
    regs_s n;    // Next state

    // Fraction of an octave as gain mantissa, 1.0 is 17'h10000
    function automatic logic [16:0] mant(input logic [3:0] frac);
        unique case (frac)
            4'h0:    mant = 17'h10000;
            4'h1:    mant = 17'h0f1b1;
            4'h2:    mant = 17'h0e42c;
            4'h3:    mant = 17'h0d766;
            4'h4:    mant = 17'h0cb59;
            4'h5:    mant = 17'h0bff9;
            4'h6:    mant = 17'h0b53b;
            4'h7:    mant = 17'h0ab15;
            4'h8:    mant = 17'h0a189;
            4'h9:    mant = 17'h09881;
            4'ha:    mant = 17'h08ff3;
            4'hb:    mant = 17'h087e9;
            default: mant = 17'h10000;
        endcase
    endfunction

    // Reserved codes fold onto the nearest usable gain
    function automatic logic [7:0] vol_clamp(input logic [7:0] code);
        if (!code[7] && (code > `VOL_MAX)) begin
            vol_clamp = `VOL_MAX;
        end else if (code == `VOL_RSVD) begin
            vol_clamp = `VOL_MIN;
        end else begin
            vol_clamp = code;
        end
    endfunction

    // Scale one sample by a half-dB code, octave shift plus mantissa
    function automatic logic [15:0] apply_gain(input logic [15:0] s, input logic [7:0] code);
        logic [7:0]         steps;
        logic [3:0]         oct;
        logic [3:0]         frac;
        logic signed [33:0] p;
        logic signed [40:0] w;
        steps = 8'(`VOL_MAX - code);               // Steps below +24 dB
        oct   = 4'(steps / 8'h0c);                 // Twelve steps per octave
        frac  = 4'(steps % 8'h0c);
        p     = $signed(s) * $signed({1'b0, mant(frac)});
        w     = $signed({{7{p[33]}}, p}) <<< 4;    // Headroom for +24 dB
        w     = w >>> (5'h10 + 5'(oct));
        if (w > 41'sh7fff) begin
            apply_gain = 16'h7fff;                 // Saturate high
        end else if (w < -41'sh8000) begin
            apply_gain = 16'h8000;                 // Saturate low
        end else begin
            apply_gain = w[15:0];
        end
    endfunction

    // One debounce filter step, a sample is taken every ival milliseconds
    function automatic dbn_s dbn_step(input dbn_s d, input logic [1:0] raw,
                                      input logic ms_p, input logic [6:0] ival);
        dbn_step = d;
        if (ms_p) begin
            if ((d.age + 7'h01) >= ival) begin
                dbn_step.age = 7'h00;              // Sample point
                if (raw != d.cand) begin
                    dbn_step.cand = raw;           // New candidate restarts window
                    dbn_step.hits = 4'h1;
                end else if (d.hits < `DBN_SAMPLES) begin
                    dbn_step.hits = d.hits + 4'h1;
                    if ((d.hits + 4'h1) == `DBN_SAMPLES) begin
                        dbn_step.stat = d.cand;    // Stable across window
                    end
                end
            end else begin
                dbn_step.age = d.age + 7'h01;
            end
        end
    endfunction

    // Next-state logic
    always_comb begin
        logic       step_now;
        logic [7:0] tgt;
        logic [6:0] hs_ival;
        logic [6:0] btn_ival;
        n        = q;
        n.ms_p   = 1'b0;
        n.rvalid = 1'b0;
        n.out_vld = 1'b0;
        step_now = 1'b0;
        tgt      = 8'h00;
        hs_ival  = 7'h00;
        btn_ival = 7'h00;

        // Millisecond pulse from the reference tick
        if (tick_1mhz_i) begin
            if (q.us == 10'(`TICKS_PER_MS - 1)) begin
                n.us   = 10'h000;
                n.ms_p = 1'b1;
            end else begin
                n.us = q.us + 10'h001;
            end
        end

        // Register writes, status bits are read-only
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `VOL_LEFT_OFS:  n.vol[0] = reg_wdata_i;
                `VOL_RIGHT_OFS: n.vol[1] = reg_wdata_i;
                `HSET_OFS: begin
                    n.hs_en   = reg_wdata_i[`HSET_EN_BIT];
                    n.hs_deb  = reg_wdata_i[4:2];
                    n.btn_deb = reg_wdata_i[1:0];
                end
                `DRC1_OFS:      n.drc = reg_wdata_i;
                default: ;                                        // Other offsets ignored
            endcase
        end

        // Register reads, one cycle later with a valid pulse
        if (reg_rd_i) begin
            n.rvalid = 1'b1;
            unique case (reg_addr_i)
                `VOL_LEFT_OFS:  n.rdata = q.vol[0];
                `VOL_RIGHT_OFS: n.rdata = q.vol[1];
                `HSET_OFS:      n.rdata = {q.hs_en, q.hs.stat, q.hs_deb, q.btn_deb};
                `DRC1_OFS:      n.rdata = q.drc;
                default:        n.rdata = 8'h00;                  // Unmapped reads zero
            endcase
        end

        // Soft stepping: per sample, per two samples, or immediate
        if (sample_valid_i) begin
            n.half = ~q.half;
        end
        step_now = sample_valid_i && ((step_mode_i == 2'b00) ||
                                      ((step_mode_i == 2'b01) && q.half));
        for (int c = 0; c < 2; c++) begin
            tgt = vol_clamp(q.vol[c]);
            if (step_mode_i[1]) begin
                n.cur[c] = tgt;                                   // Stepping off
            end else if (step_now && ($signed(q.cur[c]) < $signed(tgt))) begin
                n.cur[c] = q.cur[c] + 8'h01;
            end else if (step_now && ($signed(q.cur[c]) > $signed(tgt))) begin
                n.cur[c] = q.cur[c] - 8'h01;
            end
        end

        // Scale samples with the current stepped gain
        if (sample_valid_i) begin
            n.out[0]  = apply_gain(sample_i.left, q.cur[0]);
            n.out[1]  = apply_gain(sample_i.right, q.cur[1]);
            n.out_vld = 1'b1;
        end

        // Insertion debounce, reserved selects act as the longest window
        hs_ival = (q.hs_deb > 3'h5) ? `HS_MAX_IVAL_MS : 7'(7'h02 << q.hs_deb);
        unique case (q.btn_deb)
            2'b01:   btn_ival = 7'h01;
            2'b10:   btn_ival = 7'h02;
            2'b11:   btn_ival = 7'h04;
            default: btn_ival = 7'h00;
        endcase
        if (!q.hs_en) begin
            n.hs  = '0;                                           // Disabled reads 00
            n.btn = '0;
        end else begin
            n.hs = dbn_step(q.hs, headset_sense_i, q.ms_p, hs_ival);
            if (q.btn_deb == 2'b00) begin
                n.btn      = '0;                                  // No filtering
                n.btn.stat = {1'b0, button_i};
            end else begin
                n.btn = dbn_step(q.btn, {1'b0, button_i}, q.ms_p, btn_ival);
            end
        end

        // Compressor settings toward the stage
        n.drc_en  = {q.drc[`DRC_RIGHT_BIT], q.drc[`DRC_LEFT_BIT]};
        n.thr_db  = (q.drc[4:2] == 3'h7) ? 5'h15 :
                    5'(5'h03 * ({2'b00, q.drc[4:2]} + 5'h01));
        n.hyst_db = q.drc[1:0];
    end

    // State register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q         <= '0;
            q.vol     <= {`VOL_RST, `VOL_RST};
            q.cur     <= {`VOL_RST, `VOL_RST};
            q.drc     <= `DRC1_RST;
            q.thr_db  <= `THR_RST_DB;
            q.hyst_db <= `HYST_RST_DB;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o      = q.rdata;
    assign reg_rvalid_o     = q.rvalid;
    assign sample_valid_o   = q.out_vld;
    assign sample_o.left    = q.out[0];
    assign sample_o.right   = q.out[1];
    assign headset_status_o = q.hs.stat;
    assign button_o         = q.btn.stat[0];
    assign drc_en_o         = q.drc_en;
    assign drc_thr_db_o     = q.thr_db;
    assign drc_hyst_db_o    = q.hyst_db;

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_left_one_step;
        (q.cur[0] == $past(q.cur[0]) + 8'h01) || (q.cur[0] == $past(q.cur[0]) - 8'h01);
    endsequence

    sequence s_drc_write;
        reg_wr_i && (reg_addr_i == `DRC1_OFS);
    endsequence

    AST_VOL_LEFT_WR: assert property (reg_wr_i && (reg_addr_i == `VOL_LEFT_OFS) |=>
        q.vol[0] == $past(reg_wdata_i)) else $error("left gain write lost");
    AST_VOL_RIGHT_WR: assert property (reg_wr_i && (reg_addr_i == `VOL_RIGHT_OFS) |=>
        q.vol[1] == $past(reg_wdata_i)) else $error("right gain write lost");
    AST_UNITY_GAIN: assert property (sample_valid_i && (q.cur[0] == 8'h00) |=>
        sample_valid_o && (sample_o.left == $past(sample_i.left))) else $error("unity gain wrong");
    AST_MIN_GAIN: assert property (sample_valid_i && (q.cur[0] == `VOL_MIN) &&
        (sample_i.left == 16'h7fff) |=> sample_o.left == 16'h0015) else $error("min gain wrong");
    AST_SOFT_STEP: assert property ((step_mode_i == 2'b00) && sample_valid_i &&
        (q.cur[0] != vol_clamp(q.vol[0])) |=> s_left_one_step) else $error("step size wrong");
    AST_IMMEDIATE: assert property ((step_mode_i == 2'b10) |=>
        q.cur[0] == vol_clamp($past(q.vol[0]))) else $error("immediate gain not applied");
    AST_HS_OFF: assert property (!q.hs_en |=> headset_status_o == 2'b00)
        else $error("status while detection off");
    AST_HS_WINDOW: assert property ($past(q.hs_en) && $changed(headset_status_o) |->
        $past(q.ms_p) && ($past(q.hs.hits) == 4'h7)) else $error("status changed early");
    AST_MS_TICK: assert property (q.ms_p |-> $past(tick_1mhz_i) && (q.us == 10'h000))
        else $error("ms pulse without tick");
    AST_BTN_BYPASS: assert property (q.hs_en && (q.btn_deb == 2'b00) && !reg_wr_i |=>
        button_o == $past(button_i)) else $error("button bypass wrong");
    AST_DRC_EN: assert property (s_drc_write |-> ##2
        drc_en_o == {$past(reg_wdata_i[5], 2), $past(reg_wdata_i[6], 2)}) else $error("drc enable wrong");
    AST_DRC_THR: assert property (s_drc_write |-> ##2
        (drc_thr_db_o == (($past(reg_wdata_i[4:2], 2) == 3'h7) ? 5'h15 :
        5'(5'h03 * {2'b00, $past(reg_wdata_i[4:2], 2)} + 5'h03))) &&
        (drc_hyst_db_o == $past(reg_wdata_i[1:0], 2)))
        else $error("drc threshold or hysteresis wrong");
    AST_STREAM: assert property (sample_valid_i |=> sample_valid_o)
        else $error("scaled sample missing");

    // Every read strobe gets exactly one answer cycle
    AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read answer missing");
    AST_RD_PULSE: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read answer without request");

endmodule

// ===== testbench/tb.sv
// Self-checking bench for the playback gain, headset detection and compressor registers
`timescale 1ns/1ns
`include "dac_vol_consts.svh"

module tb
    import dac_vol_pkg::*;
;
    logic        mclk_i          = 1'b0;   // System clock
    logic        rst_i           = 1'b1;   // Synchronous reset
    logic        reg_wr_i        = 1'b0;   // Write strobe
    logic        reg_rd_i        = 1'b0;   // Read strobe
    logic [7:0]  reg_addr_i      = 8'h00;  // Register offset
    logic [7:0]  reg_wdata_i     = 8'h00;  // Write data
    logic [7:0]  reg_rdata_o;              // Read data
    logic        reg_rvalid_o;             // Read data valid
    logic [1:0]  step_mode_i     = 2'h2;   // Immediate gain steps to start with
    logic        tick_1mhz_i     = 1'b1;   // Tick every cycle so 1 ms is 1000 cycles
    logic [1:0]  headset_sense_i = 2'h0;   // Raw insertion state
    logic        button_i        = 1'b0;   // Raw button state
    logic        sample_valid_i  = 1'b0;   // Sample strobe
    stereo_s     sample_i        = '0;     // Samples in
    logic        sample_valid_o;           // Scaled strobe
    stereo_s     sample_o;                 // Scaled samples
    logic [1:0]  headset_status_o;         // Debounced insertion state
    logic        button_o;                 // Debounced button
    logic [1:0]  drc_en_o;                 // Compressor enables
    logic [4:0]  drc_thr_db_o;             // Threshold magnitude
    logic [1:0]  drc_hyst_db_o;            // Hysteresis
    int          bad_count       = 0;      // Mismatches seen
    int          total_checks    = 0;      // Comparisons made

    dac_volume_headset_drc_regs dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .step_mode_i(step_mode_i), .tick_1mhz_i(tick_1mhz_i),
        .headset_sense_i(headset_sense_i), .button_i(button_i),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_valid_o(sample_valid_o),
        .sample_o(sample_o), .headset_status_o(headset_status_o), .button_o(button_o),
        .drc_en_o(drc_en_o), .drc_thr_db_o(drc_thr_db_o), .drc_hyst_db_o(drc_hyst_db_o)
    );

    // Free-running 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    // Verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One comparison with four-state equality
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One register write, strobe held for one edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk_i) #1;
        reg_wr_i    = 1'b1;
        reg_addr_i  = addr;
        reg_wdata_i = data;
        @(posedge mclk_i) #1;
        reg_wr_i    = 1'b0;
    endtask

    // One register read, answer expected one edge after the request edge
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge mclk_i) #1;
        reg_rd_i   = 1'b1;
        reg_addr_i = addr;
        @(posedge mclk_i) #1;
        reg_rd_i   = 1'b0;
        chk("reg_rvalid_o", 32'h1, {31'h0, reg_rvalid_o});
        chk("reg_rdata_o", {24'h0, exp}, {24'h0, reg_rdata_o});
    endtask

    // One stereo sample; an all-unknown expectation skips that channel
    task automatic smp(input logic [15:0] l, input logic [15:0] r,
                       input logic [15:0] el, input logic [15:0] er);
        @(posedge mclk_i) #1;
        sample_valid_i = 1'b1;
        sample_i       = '{left: l, right: r};
        @(posedge mclk_i) #1;
        sample_valid_i = 1'b0;
        chk("sample_valid_o", 32'h1, {31'h0, sample_valid_o});
        if (el !== 16'hxxxx) begin
            chk("sample_o.left", {16'h0, el}, {16'h0, sample_o.left});
        end
        if (er !== 16'hxxxx) begin
            chk("sample_o.right", {16'h0, er}, {16'h0, sample_o.right});
        end
    endtask

    // Bounded wait on status (sel 0) or button (sel 1); running out ends the run
    task automatic wait_until(input bit sel, input logic [1:0] exp, input int ms);
        logic [1:0] got;
        for (int i = 0; i < ms * `TICKS_PER_MS; i++) begin
            @(posedge mclk_i) #1;
            got = sel ? {1'b0, button_o} : headset_status_o;
            total_checks++;
            if (got === exp) begin
                return;
            end
        end
        bad_count++;
        $display("ERROR %s expected %h seen %h", sel ? "button_o" : "headset_status_o", exp, got);
        stop_test();
    endtask

    // Reset values, unmapped offset and compressor outputs after reset
    task automatic t_reset();
        rd(`VOL_LEFT_OFS, `VOL_RST);
        rd(`VOL_RIGHT_OFS, `VOL_RST);
        rd(`HSET_OFS, `HSET_RST);
        rd(`DRC1_OFS, `DRC1_RST);
        chk("drc_en_o", 32'h0, {30'h0, drc_en_o});
        chk("drc_thr_db_o", 32'hc, {27'h0, drc_thr_db_o});
        chk("drc_hyst_db_o", 32'h3, {30'h0, drc_hyst_db_o});
        wr(8'h45, 8'hff);
        rd(8'h45, 8'h00);
        rd(`DRC1_OFS, `DRC1_RST);
    endtask

    // Gain codes at both ends of the range, immediate stepping
    task automatic t_gain();
        wr(`VOL_LEFT_OFS, `VOL_MAX);
        wr(`VOL_RIGHT_OFS, 8'hff);
        repeat (2) @(posedge mclk_i);
        rd(`VOL_LEFT_OFS, `VOL_MAX);
        rd(`VOL_RIGHT_OFS, 8'hff);
        smp(16'h0100, 16'h4000, 16'h1000, 16'h3c6c);
        wr(`VOL_LEFT_OFS, 8'h00);
        wr(`VOL_RIGHT_OFS, `VOL_MIN);
        repeat (2) @(posedge mclk_i);
        smp(16'h1234, 16'h7fff, 16'h1234, 16'h0015);
        wr(`VOL_LEFT_OFS, `VOL_MIN);
        wr(`VOL_RIGHT_OFS, `VOL_MAX);
        repeat (2) @(posedge mclk_i);
        smp(16'h7fff, 16'h7fff, 16'h0015, 16'h7fff);
        smp(16'h8000, 16'h8000, 16'hffea, 16'h8000);
    endtask

    // Soft stepping one code per sample, then per two samples
    task automatic t_step();
        wr(`VOL_LEFT_OFS, 8'h00);
        repeat (2) @(posedge mclk_i);
        #1;
        step_mode_i = 2'h0;
        wr(`VOL_LEFT_OFS, 8'h02);
        smp(16'h1000, 16'h0000, 16'h1000, 16'h0000);
        smp(16'h1000, 16'h0000, 16'h10fd, 16'h0000);
        smp(16'h1000, 16'h0000, 16'h11fe, 16'h0000);
        smp(16'h1000, 16'h0000, 16'h11fe, 16'h0000);
        step_mode_i = 2'h1;
        wr(`VOL_LEFT_OFS, 8'h00);
        smp(16'h1000, 16'h0000, 16'h11fe, 16'h0000);
        smp(16'h1000, 16'h0000, 16'h11fe, 16'h0000);
        smp(16'h1000, 16'h0000, 16'h10fd, 16'h0000);
    endtask

    // Every threshold code with enables and hysteresis varied
    task automatic t_drc();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {1'b0, i[0], i[1], i[2:0], i[1:0]};
            wr(`DRC1_OFS, v);
            repeat (2) @(posedge mclk_i);
            #1;
            chk("drc_en_o", {30'h0, i[1], i[0]}, {30'h0, drc_en_o});
            chk("drc_thr_db_o", (i == 7) ? 32'd21 : 32'(3 * (i + 1)),
                {27'h0, drc_thr_db_o});
            chk("drc_hyst_db_o", {30'h0, i[1:0]}, {30'h0, drc_hyst_db_o});
            rd(`DRC1_OFS, v);
        end
    endtask

    // Insertion and button debounce, tick dependence, disable and bypass
    task automatic t_headset();
        wr(`HSET_OFS, 8'h81);
        headset_sense_i = 2'h1;
        repeat (12 * `TICKS_PER_MS) @(posedge mclk_i);
        #1;
        chk("headset_status_o", 32'h0, {30'h0, headset_status_o});
        wait_until(1'b0, 2'h1, 8);
        rd(`HSET_OFS, 8'ha1);
        wr(`HSET_OFS, 8'h85);
        headset_sense_i = 2'h3;
        button_i        = 1'b1;
        repeat (5 * `TICKS_PER_MS) @(posedge mclk_i);
        #1;
        chk("button_o", 32'h0, {31'h0, button_o});
        wait_until(1'b1, 2'h1, 6);
        repeat (12 * `TICKS_PER_MS) @(posedge mclk_i);
        #1;
        chk("headset_status_o", 32'h1, {30'h0, headset_status_o});
        wait_until(1'b0, 2'h3, 16);
        rd(`HSET_OFS, 8'he5);
        tick_1mhz_i     = 1'b0;
        headset_sense_i = 2'h0;
        repeat (20 * `TICKS_PER_MS) @(posedge mclk_i);
        #1;
        chk("headset_status_o", 32'h3, {30'h0, headset_status_o});
        tick_1mhz_i = 1'b1;
        wr(`HSET_OFS, 8'h00);
        @(posedge mclk_i) #1;
        chk("headset_status_o", 32'h0, {30'h0, headset_status_o});
        chk("button_o", 32'h0, {31'h0, button_o});
        wr(`HSET_OFS, 8'h80);
        @(posedge mclk_i) #1;
        chk("button_o", 32'h1, {31'h0, button_o});
        button_i = 1'b0;
        @(posedge mclk_i) #1;
        chk("button_o", 32'h0, {31'h0, button_o});
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_gain();
        t_step();
        t_drc();
        t_headset();
        stop_test();
    end
endmodule
